//--- logic/clkgen_ctrl.sv
/*
 * clock generation control: pll and on-chip oscillator run control,
 * base clock source choice, wait mode gating of the cpu and bus clocks,
 * watchdog count path keep-alive.
 * assumes control bits are synchronous to mclk, one clock domain, and
 * the oscillator run/enable outputs drive the analog cells directly.
 */
`timescale 1ns/1ns
`default_nettype none

module clkgen_ctrl
    import clkgen_pkg::*;
(
    // clock and reset
    input  wire logic  mclk,
    input  wire logic  rst,
    // source clocks
    input  wire logic  main_clk,
    input  wire logic  sub_clk,
    input  wire logic  pll_clk,
    input  wire logic  osc_clk,
    // software control
    input  wire clk_ctrl_t ctrl,
    input  wire logic  wait_req,
    // option area boot flags
    input  wire logic  osc_boot_stop_flag,
    input  wire logic  osc_boot_run_flag,
    // oscillator controls
    output logic       pll_run,
    output logic       main_osc_run,
    output logic       onchip_osc_run,
    output logic       onchip_osc_ready,
    // clocks out
    output logic       base_clk,
    output logic       cpu_clk,
    output logic       bus_clk,
    output logic       main_clk_out,
    output logic       sub_clk_out,
    output logic       pll_clk_out,
    output logic       osc_clk_out,
    // watchdog
    output logic       wdt_clk,
    output logic       prescaler_clk,
    output logic       wdt_count_en,
    // status
    output logic       in_wait
);

    ctl_state_t st_r;
    ctl_state_t st_nxt;
    logic       start_req;
    logic       base_raw;
    logic       base_en;
    logic       keep_wdt;

    // =================================================================
    // oscillator start logic
    // =================================================================

    // any of three bits starts oscillator
    assign start_req = ctrl.onchip_osc_enable | ctrl.wdt_source_select
                     | ctrl.prescaler_source_select;

    // next state
    always_comb begin
        st_nxt           = st_r;
        st_nxt.boot_seen = 1'b1;
        st_nxt.wait_r    = wait_req;
        case (st_r.osc_st)
            OSC_HELD: begin
                if (!st_r.boot_seen) begin
                    if (!(osc_boot_stop_flag && !osc_boot_run_flag)) begin
                        st_nxt.osc_st = OSC_RUNNING;
                    end
                end else if (start_req) begin
                    st_nxt.osc_st = OSC_RUNNING;
                end
            end
            OSC_RUNNING: begin
                st_nxt.osc_st = OSC_RUNNING;
            end
            default: begin
                st_nxt.osc_st = OSC_HELD;
            end
        endcase
    end

    // state register
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_r <= '{osc_st: OSC_HELD, boot_seen: 1'b0, wait_r: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    // ready follows run with no wait
    assign onchip_osc_run   = (st_r.osc_st == OSC_RUNNING);
    assign onchip_osc_ready = onchip_osc_run;

    // =================================================================
    // pll and main oscillator run control
    // =================================================================

    // pll cannot stop while it is the base
    assign pll_run      = (ctrl.base_src_select == `BASE_SRC_PLL) | ~ctrl.main_clk_stop;
    assign main_osc_run = ~ctrl.main_clk_stop;

    // =================================================================
    // base clock select and wait gating
    // =================================================================

    assign base_raw = (ctrl.base_src_select == `BASE_SRC_PLL) ? pll_clk : main_clk;

    assign base_en = ~st_r.wait_r;
    assign in_wait = st_r.wait_r;

    // low phase gate on base clock
    clk_gate_low clk_gate_low_inst (
        .clk_in  (base_raw),
        .rst     (rst),
        .enable  (base_en),
        .clk_out (base_clk)
    );

    assign cpu_clk = base_clk;
    assign bus_clk = base_clk;

    // source clocks never gated by wait
    assign main_clk_out = main_clk;
    assign sub_clk_out  = sub_clk;
    assign pll_clk_out  = pll_clk;
    assign osc_clk_out  = osc_clk & onchip_osc_run;

    // =================================================================
    // watchdog paths
    // =================================================================

    assign keep_wdt     = ctrl.wdt_source_select | ctrl.prescaler_source_select;
    assign wdt_count_en = ~st_r.wait_r | keep_wdt;
    assign wdt_clk      = ctrl.wdt_source_select ? osc_clk_out : bus_clk;

    assign prescaler_clk = ctrl.prescaler_source_select ? osc_clk_out : bus_clk;

    // =================================================================
    // checks
    // =================================================================

    pll_keep_a: assert property (@(posedge mclk) disable iff (rst)
        (ctrl.base_src_select == `BASE_SRC_PLL) |-> pll_run)
        else $error("pll stopped while base source");

    osc_start_a: assert property (@(posedge mclk) disable iff (rst)
        (st_r.boot_seen && start_req) |=> onchip_osc_run)
        else $error("oscillator not started by write");

    osc_hold_a: assert property (@(posedge mclk) disable iff (rst)
        (!st_r.boot_seen && osc_boot_stop_flag && !osc_boot_run_flag && !start_req)
        |=> !onchip_osc_run)
        else $error("oscillator ran against boot flags");

    osc_boot_run_a: assert property (@(posedge mclk) disable iff (rst)
        (!st_r.boot_seen && !(osc_boot_stop_flag && !osc_boot_run_flag))
        |=> onchip_osc_run)
        else $error("oscillator held against boot flags");

    osc_gate_off_a: assert property (@(posedge mclk) disable iff (rst)
        !onchip_osc_run |-> !osc_clk_out)
        else $error("oscillator clock while stopped");

    osc_ready_a: assert property (@(posedge mclk) disable iff (rst)
        onchip_osc_run |-> onchip_osc_ready)
        else $error("oscillator ready delayed");

    wait_enter_a: assert property (@(posedge mclk) disable iff (rst)
        wait_req |=> in_wait)
        else $error("wait flag not set");

    wait_exit_a: assert property (@(posedge mclk) disable iff (rst)
        !wait_req |=> !in_wait)
        else $error("wait flag not cleared");

    wdt_stop_a: assert property (@(posedge mclk) disable iff (rst)
        (in_wait && !ctrl.wdt_source_select && !ctrl.prescaler_source_select)
        |-> !wdt_count_en)
        else $error("watchdog ran in wait");

    wdt_keep_a: assert property (@(posedge mclk) disable iff (rst)
        (in_wait && ctrl.prescaler_source_select) |-> wdt_count_en)
        else $error("watchdog halted despite oscillator source");

    wdt_src_keep_a: assert property (@(posedge mclk) disable iff (rst)
        (in_wait && ctrl.wdt_source_select) |-> wdt_count_en)
        else $error("watchdog halted despite its source");

    osc_stays_a: assert property (@(posedge mclk) disable iff (rst)
        onchip_osc_run |=> onchip_osc_run)
        else $error("oscillator stopped");

endmodule : clkgen_ctrl

`default_nettype wire

//--- logic/clkgen_regs.svh
/*
 * constants for the clock generation and wait mode control block.
 * assumes inclusion by bare name from the package and design files.
 */
`ifndef CLKGEN_REGS_SVH
`define CLKGEN_REGS_SVH

// =====================================================================
// control bit reset values
// =====================================================================
`define BASE_SRC_RST        1'h0
`define MAIN_STOP_RST       1'h0
`define OSC_EN_RST          1'h0
`define WDT_SRC_RST         1'h0
`define PRE_SRC_RST         1'h0

// =====================================================================
// base clock source encodings
// =====================================================================
`define BASE_SRC_PLL        1'h0
`define BASE_SRC_MAIN       1'h1

// =====================================================================
// timing counts
// =====================================================================
`define OSC_START_WAIT_CYC  0

`endif

//--- logic/clkgen_pkg.sv
/*
 * types shared by the clock generation block.
 * assumes clkgen_regs.svh is on the include path.
 */
`include "clkgen_regs.svh"

package clkgen_pkg;

    // =================================================================
    // software control bits
    // =================================================================
    typedef struct packed {
        logic base_src_select;
        logic main_clk_stop;
        logic onchip_osc_enable;
        logic wdt_source_select;
        logic prescaler_source_select;
    } clk_ctrl_t;

    // =================================================================
    // oscillator start state
    // =================================================================
    typedef enum logic {
        OSC_HELD,
        OSC_RUNNING
    } osc_state_t;

    // =================================================================
    // gate cell state
    // =================================================================
    typedef struct packed {
        logic en_r;
    } gate_state_t;

    // =================================================================
    // controller state
    // =================================================================
    typedef struct packed {
        osc_state_t osc_st;
        logic       boot_seen;
        logic       wait_r;
    } ctl_state_t;

endpackage : clkgen_pkg

//--- logic/clk_gate_low.sv
/*
 * glitch free clock gate; the enable is retimed on the low phase.
 * assumes a free running source clock and a synchronous enable.
 */
`timescale 1ns/1ns
`default_nettype none

module clk_gate_low
    import clkgen_pkg::*;
(
    // source
    input  wire logic clk_in,
    input  wire logic rst,
    // control
    input  wire logic enable,
    // gated result
    output logic      clk_out
);

    gate_state_t st_r;
    gate_state_t st_nxt;

    // next enable
    always_comb begin
        st_nxt      = st_r;
        st_nxt.en_r = enable;
    end

    always_ff @(negedge clk_in or posedge rst) begin
        if (rst) begin
            st_r <= '{en_r: 1'b1};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign clk_out = clk_in & st_r.en_r;

    gate_stable_a: assert property (@(clk_in) disable iff (rst)
        clk_in |-> $stable(st_r.en_r))
        else $error("gate enable moved on high phase");

endmodule : clk_gate_low

`default_nettype wire

//--- sim/tb_clkgen_ctrl.sv
/*
 * self-checking bench for clkgen_ctrl: status levels and clock activity.
 * assumes clkgen_pkg is compiled and clkgen_regs.svh is on the path.
 */
`timescale 1ns/1ns
`default_nettype none
`include "clkgen_regs.svh"

module tb_clkgen_ctrl
    import clkgen_pkg::*;
;
    // =================================================================
    // signals
    // =================================================================
    logic        mclk = 0, rst = 1, main_clk = 0, sub_clk = 0, pll_clk = 0, osc_clk = 0;
    clk_ctrl_t   ctrl = '0;
    logic        wait_req = 0, osc_boot_stop_flag = 0, osc_boot_run_flag = 0;
    logic        pll_run, main_osc_run, onchip_osc_run, onchip_osc_ready, in_wait;
    logic        base_clk, cpu_clk, bus_clk, main_clk_out, sub_clk_out, pll_clk_out;
    logic        osc_clk_out, wdt_clk, prescaler_clk, wdt_count_en, osc_on, chk_gl = 0;
    int          fails = 0, n_checks = 0, cyc = 0, seed = 32'h0ffd2682, cnt[9], last[9];
    logic [29:0] notes[$];
    event        smp;
    time         t_rise = 0;

    // source clocks; pll and main only swing while their cells run
    always #20 mclk = ~mclk;
    always #10 pll_clk = (pll_run === 1'b1) ? ~pll_clk : 1'b0;
    always #25 main_clk = (main_osc_run === 1'b1) ? ~main_clk : 1'b0;
    always #30 sub_clk = ~sub_clk;
    always #7 osc_clk = ~osc_clk;

    clkgen_ctrl clkgen_ctrl_inst (.mclk, .rst, .main_clk, .sub_clk, .pll_clk, .osc_clk,
        .ctrl, .wait_req, .osc_boot_stop_flag, .osc_boot_run_flag, .pll_run, .main_osc_run,
        .onchip_osc_run, .onchip_osc_ready, .base_clk, .cpu_clk, .bus_clk, .main_clk_out,
        .sub_clk_out, .pll_clk_out, .osc_clk_out, .wdt_clk, .prescaler_clk, .wdt_count_en,
        .in_wait);

    // =================================================================
    // observation
    // =================================================================
    wire logic [8:0] oc = {prescaler_clk, wdt_clk, osc_clk_out, pll_clk_out, sub_clk_out,
                           main_clk_out, bus_clk, cpu_clk, base_clk};

    // edge counters, one per output clock
    for (genvar g = 0; g < 9; g++) begin : g_cnt
        always @(posedge oc[g]) cnt[g]++;
    end

    // compare the oldest note with levels and activity since the last note
    always @(smp) begin : mon
        logic [29:0] n;
        logic [14:0] act;
        n = notes.pop_front();
        for (int i = 0; i < 9; i++) begin
            act[i] = (cnt[i] != last[i]);
            last[i] = cnt[i];
        end
        act[14:9] = {pll_run, main_osc_run, onchip_osc_run, onchip_osc_ready, wdt_count_en, in_wait};
        if (n[29:15] != 15'h0) begin
            n_checks++;
            if (((act ^ n[14:0]) & n[29:15]) !== 15'h0) begin
                fails++;
                $display("Error at %0t: exp %h act %h", $time, n[14:0] & n[29:15], act & n[29:15]);
            end
        end
    end

    // short high pulse watch on the cpu clock
    always @(posedge cpu_clk) t_rise = $time;
    always @(negedge cpu_clk) begin
        if (chk_gl && t_rise > 0 && $time - t_rise < 10) begin
            fails++;
            $display("Error at %0t: exp %h act %h", $time, 10, $time - t_rise);
        end
    end

    // cycle ceiling against a hang
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            stop_test();
        end
    end

    // =================================================================
    // tasks
    // =================================================================
    task automatic note(input logic [14:0] m, input logic [14:0] e);
        #1;
        notes.push_back({m, e});
        -> smp;
        #1;
    endtask : note

    task automatic do_reset(input logic s, input logic r);
        @(negedge mclk);
        rst = 1;
        osc_boot_stop_flag = s;
        osc_boot_run_flag = r;
        ctrl = '0;
        wait_req = 0;
        repeat (10) @(negedge mclk);
        rst = 0;
        osc_on = !(s && !r);
        @(negedge mclk);
    endtask : do_reset

    // expected {mask, levels and activity}; pll state is free with main base
    function automatic logic [29:0] model(input clk_ctrl_t c, input logic w, input logic o);
        logic pll, b;
        pll = (c.base_src_select == `BASE_SRC_PLL);
        b = (pll | ~c.main_clk_stop) & ~w;
        model[14:0] = {pll, ~c.main_clk_stop, o, o,
                       ~w | c.wdt_source_select | c.prescaler_source_select, w,
                       c.prescaler_source_select ? o : b, c.wdt_source_select ? o : b,
                       o, pll, 1'b1, ~c.main_clk_stop, b, b, b};
        model[29:15] = {pll, 8'hFF, pll, 5'h1F};
    endfunction : model

    task automatic run_case(input clk_ctrl_t c, input logic w);
        logic [29:0] m;
        @(negedge mclk);
        ctrl = c;
        wait_req = w;
        osc_on = osc_on | c.onchip_osc_enable | c.wdt_source_select | c.prescaler_source_select;
        m = model(c, w, osc_on);
        repeat (4) @(negedge mclk);
        note(15'h0, 15'h0);
        repeat (8) @(negedge mclk);
        note(m[29:15], m[14:0]);
    endtask : run_case

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : stop_test

    // =================================================================
    // sequence
    // =================================================================
    initial begin : main_seq
        chk_gl = 1;
        // held oscillator, started by each of the three bits
        for (int k = 0; k < 3; k++) begin
            do_reset(1'b1, 1'b0);
            repeat (5) @(negedge mclk);
            note(15'h0, 15'h0);
            repeat (8) @(negedge mclk);
            note(15'h1840, 15'h0);
            @(negedge mclk);
            ctrl = clk_ctrl_t'(5'(1 << k));
            note(15'h1800, 15'h0);
            @(negedge mclk);
            note(15'h1800, 15'h1800);
            run_case(clk_ctrl_t'(5'(1 << k)), 1'b1);
            run_case(clk_ctrl_t'(5'(1 << k)), 1'b0);
        end
        chk_gl = 0;
        do_reset(1'b0, 1'b0);
        run_case(clk_ctrl_t'(5'h08), 1'b0);
        run_case(clk_ctrl_t'(5'h08), 1'b1);
        run_case(clk_ctrl_t'(5'h10), 1'b1);
        // random controls, straps and wait requests
        for (int i = 0; i < 16; i++) begin
            if (seed[3]) do_reset(1'($random(seed)), 1'($random(seed)));
            run_case(clk_ctrl_t'(5'($random(seed))), 1'($random(seed)));
        end
        stop_test();
    end
endmodule : tb_clkgen_ctrl
`default_nettype wire
